// [bench/adr_result_status_irq_tb.sv]
/*
  Self-checking bench for the converter result, status and enable block.
  Assumes adr_pkg is compiled first and the block is a zero-wait APB slave.
*/
`timescale 1ns/1ps

module adr_result_status_irq_tb;
  logic               mclk;
  logic               rst_n;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [31:0]        paddr;
  logic [31:0]        pwdata;
  logic               pready;
  logic [31:0]        prdata;
  logic               pslverr;
  adr_pkg::adr_conv_t conv;
  logic               conv_busy;
  logic               burst_mode;
  logic               ctrl_write;
  logic               irq;
  logic [31:0]        rd;
  logic               rerr;
  int                 err_total;
  int                 n_checks;

  adr_result_status i_adr_result_status (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .pready     (pready),
    .prdata     (prdata),
    .pslverr    (pslverr),
    .conv       (conv),
    .conv_busy  (conv_busy),
    .burst_mode (burst_mode),
    .ctrl_write (ctrl_write),
    .irq        (irq)
  );

  // ------------------------------------------------------------
  // Compare helpers
  // ------------------------------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s got %b", $time, what, got);
    end
  endtask

  function automatic logic [31:0] gexp(input logic dn, input logic ls,
                                       input logic [2:0] ch, input logic [9:0] v);
    gexp = {dn, ls, 3'h0, ch, 8'h00, v, 6'h00};
  endfunction

  // ------------------------------------------------------------
  // Bus and core drivers
  // ------------------------------------------------------------
  // Request held from setup until pready is seen high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk_bit(pready, 1'b1, "pready");
    rd      = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_word(rd, exp);
  endtask

  // One-cycle finished-conversion pulse
  task automatic cv(input logic [2:0] ch, input logic [9:0] v);
    @(posedge mclk);
    conv <= '{valid: 1'b1, chan: ch, value: v};
    @(posedge mclk);
    conv <= '0;
  endtask

  // Request is registered, so allow its one-cycle lag
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge mclk);
    #1;
    chk_bit(irq, exp, "irq");
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rdc(adr_pkg::ADR_INTEN_ADDR, 32'h0000_0100);
    rdc(adr_pkg::ADR_GLOB_ADDR, 32'h0000_0000);
    rdc(adr_pkg::ADR_STAT_ADDR, 32'h0000_0000);
    chk_bit(irq, 1'b0, "irq");
    $display("t_reset done");
  endtask

  task automatic t_conv;
    cv(3'h5, 10'h3ff);
    rdc(adr_pkg::ADR_STAT_ADDR, 32'h0000_0020);
    irq_is(1'b1);
    rdc(adr_pkg::ADR_GLOB_ADDR, gexp(1'b1, 1'b0, 3'h5, 10'h3ff));
    rdc(adr_pkg::ADR_GLOB_ADDR, gexp(1'b0, 1'b0, 3'h5, 10'h3ff));
    irq_is(1'b0);
    $display("t_conv done");
  endtask

  // Two results on one channel with no read between them
  task automatic t_loss;
    @(posedge mclk);
    burst_mode <= 1'b1;
    cv(3'h2, 10'h12a);
    cv(3'h2, 10'h2d5);
    rdc(adr_pkg::ADR_STAT_ADDR, 32'h0000_0424);
    rdc(adr_pkg::ADR_STAT_ADDR, 32'h0000_0424);
    rdc(adr_pkg::ADR_GLOB_ADDR, gexp(1'b1, 1'b1, 3'h2, 10'h2d5));
    rdc(adr_pkg::ADR_GLOB_ADDR, gexp(1'b0, 1'b0, 3'h2, 10'h2d5));
    burst_mode <= 1'b0;
    $display("t_loss done");
  endtask

  // Reserved bits always written as zero
  task automatic t_inten;
    apb(1'b1, adr_pkg::ADR_INTEN_ADDR, 32'h0000_0004);
    rdc(adr_pkg::ADR_INTEN_ADDR, 32'h0000_0004);
    rdc(adr_pkg::ADR_STAT_ADDR, 32'h0001_0424);
    irq_is(1'b1);
    apb(1'b1, adr_pkg::ADR_INTEN_ADDR, 32'h0000_0008);
    rdc(adr_pkg::ADR_STAT_ADDR, 32'h0000_0424);
    irq_is(1'b0);
    rdc(adr_pkg::ADR_CHAN0_ADDR + 32'h8, 32'hc000_b540);
    rdc(adr_pkg::ADR_STAT_ADDR, 32'h0000_0020);
    $display("t_inten done");
  endtask

  task automatic t_ctrl;
    apb(1'b1, adr_pkg::ADR_INTEN_ADDR, 32'h0000_0100);
    cv(3'h1, 10'h155);
    irq_is(1'b1);
    apb(1'b1, adr_pkg::ADR_CTRL_ADDR, 32'h0000_0000);
    #1;
    chk_bit(ctrl_write, 1'b1, "ctrl_write");
    @(posedge mclk);
    #1;
    chk_bit(ctrl_write, 1'b0, "ctrl_write");
    rdc(adr_pkg::ADR_GLOB_ADDR, gexp(1'b0, 1'b0, 3'h1, 10'h155));
    irq_is(1'b0);
    @(posedge mclk);
    conv_busy <= 1'b1;
    apb(1'b1, adr_pkg::ADR_CTRL_ADDR, 32'h0000_0000);
    conv_busy <= 1'b0;
    rdc(adr_pkg::ADR_GLOB_ADDR, gexp(1'b1, 1'b0, 3'h1, 10'h155));
    $display("t_ctrl done");
  endtask

  // Result just before a global read, then one during its setup cycle
  task automatic t_race;
    @(posedge mclk);
    conv <= '{valid: 1'b1, chan: 3'h6, value: 10'h0ab};
    fork
      apb(1'b0, adr_pkg::ADR_GLOB_ADDR, 32'h0000_0000);
      begin
        @(posedge mclk);
        conv <= '0;
      end
    join
    chk_word(rd, gexp(1'b1, 1'b0, 3'h6, 10'h0ab));
    fork
      apb(1'b0, adr_pkg::ADR_GLOB_ADDR, 32'h0000_0000);
      cv(3'h7, 10'h3c1);
    join
    chk_word(rd, gexp(1'b0, 1'b0, 3'h6, 10'h0ab));
    rdc(adr_pkg::ADR_GLOB_ADDR, gexp(1'b1, 1'b0, 3'h7, 10'h3c1));
    rdc(adr_pkg::ADR_GLOB_ADDR, gexp(1'b0, 1'b0, 3'h7, 10'h3c1));
    $display("t_race done");
  endtask

  task automatic t_unmapped;
    rdc(adr_pkg::ADR_STAT_ADDR + 32'h10, 32'h0000_0000);
    chk_bit(rerr, 1'b1, "pslverr");
    $display("t_unmapped done");
  endtask

  // ------------------------------------------------------------
  // Clock, verdict and main sequence
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog: the full run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge mclk);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end

  initial
  begin
    err_total  = 0;
    n_checks   = 0;
    rst_n      = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 32'h0000_0000;
    pwdata     = 32'h0000_0000;
    conv       = '0;
    conv_busy  = 1'b0;
    burst_mode = 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_conv();
    t_loss();
    t_inten();
    t_ctrl();
    t_race();
    t_unmapped();
    results();
  end
endmodule

// [rtl/adr_pkg.sv]
/*
  Package for the converter result, status and interrupt-enable block:
  register addresses, field positions, reset values and carrier types.
  Assumes a 32-bit APB with full byte addresses on paddr.
*/
package adr_pkg;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [31:0] ADR_CTRL_ADDR   = 32'he003_4000;
  localparam logic [31:0] ADR_GLOB_ADDR   = 32'he003_4004;
  localparam logic [31:0] ADR_INTEN_ADDR  = 32'he003_400c;
  localparam logic [31:0] ADR_CHAN0_ADDR  = 32'he003_4010;
  localparam logic [31:0] ADR_CHAN7_ADDR  = 32'he003_402c;
  localparam logic [31:0] ADR_STAT_ADDR   = 32'he003_4030;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int          ADR_NCH         = 8;
  localparam int          ADR_RES_LSB     = 6;
  localparam int          ADR_CHN_LSB     = 24;
  localparam int          ADR_LOSS_BIT    = 30;
  localparam int          ADR_DONE_BIT    = 31;
  localparam int          ADR_STAT_LOSS   = 8;
  localparam int          ADR_STAT_IRQ    = 16;
  localparam int          ADR_GSEL_BIT    = 8;
  localparam logic [8:0]  ADR_INTEN_RST   = 9'h100;
  localparam logic [3:0]  ADR_CHAN_IDX0   = 4'h4;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  // One finished conversion from the analog core
  typedef struct packed {
    logic       valid;
    logic [2:0] chan;
    logic [9:0] value;
  } adr_conv_t;

  // Held global result
  typedef struct packed {
    logic       done;
    logic       loss;
    logic [2:0] chan;
    logic [9:0] value;
  } adr_glob_t;

endpackage

// [rtl/adr_result_status.sv]
/*
  Result, status and interrupt-enable logic of an 8-channel 10-bit
  converter, as an APB slave with zero wait states.
  Assumes the analog core and the trigger logic run on mclk and hand
  each finished conversion over as a one-cycle valid pulse, and that
  the control register lives outside and reacts to ctrl_write.
*/
// Register access over APB was chosen for this implementation.
// Functional notes
// - Result fraction in global bits 15:6
// - Source channel number in bits 26:24
// - Burst loss flag bit 30, read clears
// - Completion flag bit 31 on finish
// - Result read or control write clears completion
// - Control write while busy sets completion, restarts
// - Status bits 7:0 mirror channel completion
// - Status bits 15:8 mirror channel loss
// - Status bit 16: enabled completion present
// - Enable bit n gates channel n, reset 0
// - Enable bit 8 selects global flag, reset 1
// - Interrupt follows completion, read negates it
`timescale 1ns/1ps

module adr_result_status (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire adr_pkg::adr_conv_t conv,
  input  wire logic              conv_busy,
  input  wire logic              burst_mode,
  output logic                   ctrl_write,
  output logic                   irq
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  adr_pkg::adr_glob_t glob_ff;
  adr_pkg::adr_glob_t nxt_glob;
  logic [9:0]         ch_value_ff [adr_pkg::ADR_NCH];
  logic [9:0]         nxt_ch_value [adr_pkg::ADR_NCH];
  logic [7:0]         ch_done_ff;
  logic [7:0]         nxt_ch_done;
  logic [7:0]         ch_loss_ff;
  logic [7:0]         nxt_ch_loss;
  logic [8:0]         inten_ff;
  logic [8:0]         nxt_inten;
  logic               stale_ff;
  logic               nxt_stale;
  logic [31:0]        prdata_ff;
  logic [31:0]        nxt_prdata;
  logic               ctrl_write_ff;
  logic               irq_ff;
  logic               nxt_irq;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic       setup;
  logic       acc;
  logic       hit_ctrl;
  logic       hit_glob;
  logic       hit_inten;
  logic       hit_stat;
  logic       hit_chan;
  logic [2:0] chan_idx;
  logic       mapped;
  logic       rd_glob;
  logic       wr_ctrl;
  logic       rd_stat;
  logic [7:0] rd_chan;
  logic       irq_flag;
  logic [31:0] rd_mux;

  // Address match; channel registers sit one word apart
  always_comb
  begin
    setup     = psel & ~penable;
    acc       = psel & penable;
    hit_ctrl  = paddr == adr_pkg::ADR_CTRL_ADDR;
    hit_glob  = paddr == adr_pkg::ADR_GLOB_ADDR;
    hit_inten = paddr == adr_pkg::ADR_INTEN_ADDR;
    hit_stat  = paddr == adr_pkg::ADR_STAT_ADDR;
    hit_chan  = (paddr >= adr_pkg::ADR_CHAN0_ADDR) &&
                (paddr <= adr_pkg::ADR_CHAN7_ADDR) &&
                (paddr[1:0] == 2'h0);
    chan_idx  = 3'(paddr[5:2] - adr_pkg::ADR_CHAN_IDX0);
    mapped    = hit_ctrl | hit_glob | hit_inten | hit_stat | hit_chan;
  end

  // Clearing reads are suppressed when a result landed after the
  // read data was sampled, so no unseen completion is ever wiped
  always_comb
  begin
    rd_glob = acc & ~pwrite & hit_glob & ~stale_ff;
    wr_ctrl = acc & pwrite & hit_ctrl;
    rd_stat = acc & ~pwrite & hit_stat;
    rd_chan = '0;
    if (acc && !pwrite && hit_chan && !stale_ff)
    begin
      rd_chan[chan_idx] = 1'b1;
    end
  end

  // Zero wait states; unmapped words answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = prdata_ff;

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Enabled completion summary for status bit 16
  assign irq_flag = |(ch_done_ff & inten_ff[7:0]);

  // Read word built from held state; reserved bits read as zero
  always_comb
  begin
    rd_mux = '0;
    if (hit_glob)
    begin
      rd_mux[adr_pkg::ADR_RES_LSB +: 10] = glob_ff.value;
      rd_mux[adr_pkg::ADR_CHN_LSB +: 3]  = glob_ff.chan;
      rd_mux[adr_pkg::ADR_LOSS_BIT]      = glob_ff.loss;
      rd_mux[adr_pkg::ADR_DONE_BIT]      = glob_ff.done;
    end
    else if (hit_chan)
    begin
      rd_mux[adr_pkg::ADR_RES_LSB +: 10] = ch_value_ff[chan_idx];
      rd_mux[adr_pkg::ADR_LOSS_BIT]      = ch_loss_ff[chan_idx];
      rd_mux[adr_pkg::ADR_DONE_BIT]      = ch_done_ff[chan_idx];
    end
    else if (hit_inten)
    begin
      rd_mux[8:0] = inten_ff;
    end
    else if (hit_stat)
    begin
      rd_mux[7:0]                        = ch_done_ff;
      rd_mux[adr_pkg::ADR_STAT_LOSS +: 8] = ch_loss_ff;
      rd_mux[adr_pkg::ADR_STAT_IRQ]      = irq_flag;
    end
  end

  // Sample in setup, hold through access; note late arrivals
  always_comb
  begin
    nxt_prdata = setup ? rd_mux : prdata_ff;
    nxt_stale  = setup ? conv.valid : stale_ff;
  end

  // ------------------------------------------------------------
  // Global result
  // ------------------------------------------------------------
  // A new result or a restart sets completion over any clear
  always_comb
  begin
    nxt_glob = glob_ff;
    if (rd_glob || wr_ctrl)
    begin
      nxt_glob.done = 1'b0;
    end
    if (rd_glob)
    begin
      nxt_glob.loss = 1'b0;
    end
    if (conv.valid)
    begin
      nxt_glob.value = conv.value;
      nxt_glob.chan  = conv.chan;
      nxt_glob.done  = 1'b1;
      nxt_glob.loss  = burst_mode & glob_ff.done & ~rd_glob;
    end
    if (wr_ctrl && conv_busy)
    begin
      nxt_glob.done = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      glob_ff   <= '0;
      prdata_ff <= '0;
      stale_ff  <= 1'b0;
    end
    else
    begin
      glob_ff   <= nxt_glob;
      prdata_ff <= nxt_prdata;
      stale_ff  <= nxt_stale;
    end
  end

  // ------------------------------------------------------------
  // Per-channel results
  // ------------------------------------------------------------
  // Status reads never touch these flags
  for (genvar n = 0; n < adr_pkg::ADR_NCH; n++)
  begin : g_ch
    logic hit;
    assign hit = conv.valid && (conv.chan == 3'(n));
    always_comb
    begin
      nxt_ch_value[n] = hit ? conv.value : ch_value_ff[n];
      nxt_ch_done[n]  = (ch_done_ff[n] & ~rd_chan[n]) | hit;
      nxt_ch_loss[n]  = hit ? (burst_mode & ch_done_ff[n] & ~rd_chan[n]) :
                              (ch_loss_ff[n] & ~rd_chan[n]);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ch_value_ff[n] <= '0;
        ch_done_ff[n]  <= 1'b0;
        ch_loss_ff[n]  <= 1'b0;
      end
      else
      begin
        ch_value_ff[n] <= nxt_ch_value[n];
        ch_done_ff[n]  <= nxt_ch_done[n];
        ch_loss_ff[n]  <= nxt_ch_loss[n];
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt enable and request
  // ------------------------------------------------------------
  // Software keeps reserved bits zero, so only 8:0 are stored
  always_comb
  begin
    nxt_inten = inten_ff;
    if (acc && pwrite && hit_inten)
    begin
      nxt_inten = pwdata[8:0];
    end
    nxt_irq = inten_ff[adr_pkg::ADR_GSEL_BIT] ? glob_ff.done : irq_flag;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inten_ff      <= adr_pkg::ADR_INTEN_RST;
      irq_ff        <= 1'b0;
      ctrl_write_ff <= 1'b0;
    end
    else
    begin
      inten_ff      <= nxt_inten;
      irq_ff        <= nxt_irq;
      ctrl_write_ff <= wr_ctrl;
    end
  end

  // Registered, so both lag their cause by one cycle
  assign irq        = irq_ff;
  assign ctrl_write = ctrl_write_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_res_load;
    @(posedge mclk) disable iff (!rst_n)
    conv.valid |=> glob_ff.value == $past(conv.value);
  endproperty
  a_res_load: assert property (p_res_load)
    else $error("result not loaded");

  property p_chn_load;
    @(posedge mclk) disable iff (!rst_n)
    conv.valid ##1 (setup && hit_glob) |=>
      prdata[adr_pkg::ADR_CHN_LSB +: 3] == $past(conv.chan, 2);
  endproperty
  a_chn_load: assert property (p_chn_load)
    else $error("channel field wrong");

  property p_loss;
    @(posedge mclk) disable iff (!rst_n)
    conv.valid && burst_mode && glob_ff.done && !rd_glob |=> glob_ff.loss;
  endproperty
  a_loss: assert property (p_loss)
    else $error("loss not flagged");

  property p_done_set;
    @(posedge mclk) disable iff (!rst_n)
    conv.valid |=> glob_ff.done;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("done not set");

  property p_done_clr;
    @(posedge mclk) disable iff (!rst_n)
    (rd_glob || (wr_ctrl && !conv_busy)) && !conv.valid |=> !glob_ff.done;
  endproperty
  a_done_clr: assert property (p_done_clr)
    else $error("done not cleared");

  property p_restart;
    @(posedge mclk) disable iff (!rst_n)
    wr_ctrl && conv_busy |=> glob_ff.done && ctrl_write;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart not flagged");

  property p_stat_irq;
    @(posedge mclk) disable iff (!rst_n)
    setup && hit_stat |=>
      prdata[adr_pkg::ADR_STAT_IRQ] == |($past(ch_done_ff) & $past(inten_ff[7:0]));
  endproperty
  a_stat_irq: assert property (p_stat_irq)
    else $error("status irq bit wrong");

  property p_irq;
    @(posedge mclk) disable iff (!rst_n)
    inten_ff[adr_pkg::ADR_GSEL_BIT] && rd_glob && !conv.valid ##1
      inten_ff[adr_pkg::ADR_GSEL_BIT] |=> !irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq not negated");

  property p_stat_pure;
    @(posedge mclk) disable iff (!rst_n)
    rd_stat && !conv.valid |=> ch_done_ff == $past(ch_done_ff);
  endproperty
  a_stat_pure: assert property (p_stat_pure)
    else $error("status read changed flags");
endmodule
